// [sim/nvs_link_checker.sv]
// Link checker for the serial memory port
`timescale 1ns/1ps
module nvs_link_checker (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic store_busy_dev_o,
    input wire logic store_busy_dev_oe,
    // Memory end status
    input wire logic NV_BUSY,
    input wire logic STANDBY
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    // Select passes two sync flops, hence the slack
    chk_idle_no_drive: assert property (cs_n && $past(cs_n, 4) |-> !so_oe)
        else $error("so driven while deselected");
    chk_standby_off: assert property ($fell(cs_n) |-> ##[1:4] !STANDBY)
        else $error("no wake on select");
    chk_standby_on: assert property ($rose(cs_n) |-> ##[1:4] STANDBY)
        else $error("no standby on deselect");
    chk_so_on_fall: assert property (so_oe && $past(so_oe) && $changed(so) |-> !$past(sck, 2))
        else $error("so moved away from a falling edge");
    chk_si_held_rise: assert property ($rose(sck) && !cs_n |-> $stable(si) [*4])
        else $error("si moved around a rising edge");
    chk_select_setup: assert property ($fell(cs_n) |-> $stable(sck) [*8])
        else $error("clock edge too soon after select");
    chk_busy_pulls_low: assert property (NV_BUSY |-> store_busy_dev_oe && !store_busy_dev_o)
        else $error("busy pin not pulled low");
    chk_drive_high: assert property ($fell(NV_BUSY) && store_busy_dev_o |->
        (store_busy_dev_oe && store_busy_dev_o) [*5] ##1 !store_busy_dev_oe)
        else $error("busy pin drive-high phase wrong");
endmodule

// [sim/tb_top.sv]
// Bench: controller end and memory end joined over the serial link
`timescale 1ns/1ps
module tb_top;
    logic MCLK = 0, NRST = 0, wr = 0, rd = 0, pwr_fail = 0, nv_busy, standby, dirty;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, rdat, seed = 32'he936;
    logic [7:0] tx [8], rx [8], d [4];
    int errors = 0, n_compared = 0;
    always #2 MCLK = !MCLK;
    nvs_link_if link ();
    nvs_host #(.HALF_CYC(8)) nvs_host_i (.MCLK(MCLK), .NRST(NRST), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .LINK(link));
    // Small array keeps store and recall short
    nvs_device #(.ADDR_W(9)) nvs_device_i (.MCLK(MCLK), .NRST(NRST), .LINK(link),
        .PWR_FAIL(pwr_fail), .NV_BUSY(nv_busy), .STANDBY(standby), .MEM_DIRTY(dirty));
    nvs_link_checker nvs_link_checker_i (.MCLK(MCLK), .NRST(NRST), .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .so(link.so), .so_oe(link.so_oe),
        .store_busy_dev_o(link.store_busy_dev_o), .store_busy_dev_oe(link.store_busy_dev_oe),
        .NV_BUSY(nv_busy), .STANDBY(standby));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge MCLK);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge MCLK);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge MCLK);
        addr <= a;
        rd <= 1'b1;
        @(posedge MCLK);
        rd <= 1'b0;
        #1 v = rdat;
    endtask
    // Sends tx[0..n-1] in one frame, select dropped after the last byte
    task automatic frame(input int n);
        logic [31:0] s;
        for (int i = 0; i < n; i++) begin
            reg_wr(nvs_pkg::REG_CTRL, {23'h0, i < n - 1, tx[i]});
            s = 32'h1;
            for (int k = 0; k < 100 && s[0] !== 1'b0; k++) reg_rd(nvs_pkg::REG_STAT, s);
            check(s[0], 1'b0);
            rx[i] = s[15:8];
        end
        for (int k = 0; k < 20 && s[2] !== 1'b0; k++) reg_rd(nvs_pkg::REG_STAT, s);
        check(s[2], 1'b0);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge MCLK);
        NRST <= 1'b1;
        check(standby, 1'b1);
        foreach (d[i]) d[i] = rnd();
        tx[0] = nvs_pkg::OP_WRITE_ENABLE;
        frame(1);
        // Upper address bits ignored; burst runs over the top
        tx = '{nvs_pkg::OP_WRITE, 8'h12, 8'hff, 8'hfe, d[0], d[1], d[2], d[3]};
        frame(8);
        tx = '{nvs_pkg::OP_READ, 8'h00, 8'h01, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(8);
        foreach (d[i]) check(rx[i + 4], d[i]);
        reg_wr(nvs_pkg::REG_CFG, 32'h1);
        tx = '{nvs_pkg::OP_FAST_READ, 8'h00, 8'h00, 8'h00, 8'h5a, 8'h00, 8'h00, 8'h00};
        frame(7);
        check({rx[5], rx[6]}, {d[2], d[3]});
        reg_wr(nvs_pkg::REG_CFG, 32'h0);
        tx[0] = nvs_pkg::OP_WRITE_DISABLE;
        frame(1);
        tx = '{nvs_pkg::OP_WRITE, 8'h00, 8'h00, 8'h00, ~d[2], 8'h00, 8'h00, 8'h00};
        frame(5);
        tx = '{nvs_pkg::OP_READ, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(5);
        check(rx[4], d[2]);
        tx[0] = nvs_pkg::OP_STORE;
        frame(1);
        check(nv_busy, 1'b1);
        tx = '{nvs_pkg::OP_READ_STATUS, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        frame(2);
        check(rx[1][0], 1'b1);
        for (int k = 0; k < 2000 && nv_busy !== 1'b0; k++) @(posedge MCLK);
        check(nv_busy, 1'b0);
        check(dirty, 1'b0);
        // Nothing written since the store, so a power-loss request is skipped
        pwr_fail <= 1'b1;
        repeat (4) @(posedge MCLK);
        check(nv_busy, 1'b0);
        pwr_fail <= 1'b0;
        tx[0] = nvs_pkg::OP_RECALL;
        frame(1);
        check(nv_busy, 1'b1);
        close_out();
    end
endmodule

// [verilog/nvs_device.sv]
// Memory end: serial slave, byte array, store and recall engine
// How it works
// R1: Select low activates; high means standby
// R2: Sample input on rise, shift output on fall
// R3: Slave only, modes 0 and 3 accepted
// R4: Write is opcode, three address bytes, data
// R5: Write burst increments address, wraps to zero
// R6: Plain read: opcode, address, data, no dummy
// R7: Fast read adds one dummy byte
// R8: Read burst increments address, wraps to zero
// R9: Array of 128K bytes, address selects byte
// R10: Busy pin low during store or recall
// R11: Busy pin driven high briefly after store
// R12: Outside low on busy pin requests store
// R13: Suspend pin pauses transfer without resetting it
// R14: Refuse reads and writes while busy
// R15: Protect pin or disable command blocks writes
// R16: Two protect bits guard quarter, half, all
// R17: Decode store, recall, save off, save on
// R18: Accesses run at link rate, no waits
// R19: Accesses use volatile array; store copies all
// R20: Ready flag reads one during store or recall
// R21: Pin or power-loss store needs a prior write
// R22: Most significant bit first; low address bits
// R23: Deselect ends transfer; next byte is opcode
`timescale 1ns/1ps
module nvs_device #(
    parameter int ADDR_W = nvs_pkg::MEM_ADDR_W
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Serial link
    nvs_link_if.dev LINK,
    // System side
    input wire logic PWR_FAIL,
    output logic NV_BUSY,
    output logic STANDBY,
    output logic MEM_DIRTY
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam logic [7:0] HI_LAST = 8'(nvs_pkg::DRIVE_HI_CYC - 1);
    // Reset levels of {busy level, protect, suspend, input, clock, select}
    localparam logic [5:0] PIN_IDLE = 6'h39;

    if (ADDR_W < 9 || ADDR_W > 24) begin : g_bad_width
        $error("nvs_device: ADDR_W must lie in 9..24");
    end
    if (nvs_pkg::DRIVE_HI_CYC > 256) begin : g_bad_drive
        $error("nvs_device: drive-high interval too long");
    end

    typedef enum logic [7:0] {
        PH_OPC = 8'h01,
        PH_ADDR = 8'h02,
        PH_DUMMY = 8'h04,
        PH_WDATA = 8'h08,
        PH_RDATA = 8'h10,
        PH_SRD = 8'h20,
        PH_WSR = 8'h40,
        PH_IGN = 8'h80
    } nvs_ph_t;

    typedef enum logic [3:0] {
        NV_IDLE = 4'h1,
        NV_STORE = 4'h2,
        NV_RECALL = 4'h4,
        NV_DRIVE = 4'h8
    } nvs_nv_t;

    typedef struct packed {
        nvs_ph_t ph;
        logic [2:0] bit_cnt;
        logic [7:0] shr;
        logic [7:0] tx;
        logic so;
        logic so_oe;
        logic [7:0] opc;
        logic [1:0] abytes;
        logic [ADDR_W-1:0] addr;
        logic [1:0] ld;
        logic sck_q;
        logic wel;
        logic [1:0] bp;
        logic save_en;
        logic dirty;
        nvs_nv_t nv;
        logic [ADDR_W-1:0] nv_ptr;
        logic [7:0] hi_cnt;
        logic busy_o;
        logic busy_oe;
        logic nv_busy;
        logic standby;
    } nvs_dev_st_t;

    localparam nvs_dev_st_t ST_RST = '{ph: PH_OPC, nv: NV_IDLE, standby: 1'b1,
                                       save_en: 1'b1, default: '0};

    nvs_dev_st_t st_ff;
    nvs_dev_st_t nxt_st;
    logic [5:0] pin_raw;
    logic [5:0] pin_s;
    logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s, lvl_s;
    logic [7:0] mem [0:DEPTH-1];
    logic [7:0] nvm [0:DEPTH-1];
    logic [7:0] rd_q;
    logic mem_we;
    logic nv_we;
    logic [ADDR_W-1:0] mem_wa;
    logic [7:0] mem_wd;

    assign pin_raw = {LINK.store_busy_lvl, LINK.wp_n, LINK.hold_n, LINK.si, LINK.sck, LINK.cs_n};

    nvs_sync #(.W(6), .INIT(PIN_IDLE)) u_pin_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .d(pin_raw),
        .q(pin_s)
    );

    assign {lvl_s, wp_n_s, hold_n_s, si_s, sck_s, cs_n_s} = pin_s;

    function automatic logic is_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
        case (bp)
            nvs_pkg::BP_QUARTER: is_protected = &a[ADDR_W-1 -: 2];
            nvs_pkg::BP_HALF: is_protected = a[ADDR_W-1];
            nvs_pkg::BP_ALL: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction

    always_comb begin
        logic rise, fall, busy, go_store, go_recall, wrote, hw_req, save_req;
        logic [7:0] b;
        logic [7:0] stat;
        nxt_st = st_ff;
        mem_we = 1'b0;
        nv_we = 1'b0;
        mem_wa = st_ff.addr;
        mem_wd = st_ff.shr;
        go_store = 1'b0;
        go_recall = 1'b0;
        wrote = 1'b0;
        // A low busy pin from outside also holds off accesses
        busy = st_ff.nv_busy || !lvl_s; // [R14]
        // Edge-based, so idle-low and idle-high clocks both work
        rise = sck_s && !st_ff.sck_q && hold_n_s; // [R2] [R3] [R13]
        fall = !sck_s && st_ff.sck_q && hold_n_s; // [R2] [R3] [R13]
        b = {st_ff.shr[6:0], si_s}; // [R22]
        stat = '0;
        stat[nvs_pkg::ST_READY] = busy; // [R20]
        stat[nvs_pkg::ST_WRITE_EN] = st_ff.wel;
        stat[nvs_pkg::ST_BLOCK_PROTECT_LO] = st_ff.bp[0];
        stat[nvs_pkg::ST_BLOCK_PROTECT_HI] = st_ff.bp[1];
        stat[nvs_pkg::ST_SAVE_EN] = st_ff.save_en;
        hw_req = !lvl_s && st_ff.dirty; // [R12] [R21]
        save_req = PWR_FAIL && st_ff.save_en && st_ff.dirty; // [R21]

        nxt_st.sck_q = sck_s;
        // Two cycles from address update to array data
        nxt_st.ld = {st_ff.ld[0], 1'b0};
        if (st_ff.ld[1]) begin
            nxt_st.tx = rd_q; // [R18]
        end

        if (cs_n_s) begin
            nxt_st.ph = PH_OPC; // [R23]
            nxt_st.bit_cnt = '0; // [R23]
            nxt_st.ld = '0;
            nxt_st.so_oe = 1'b0;
            nxt_st.standby = 1'b1; // [R1]
        end else begin
            nxt_st.standby = 1'b0; // [R1]
            nxt_st.so_oe = hold_n_s; // [R13]
            if (busy && (st_ff.ph == PH_RDATA || st_ff.ph == PH_WDATA)) begin
                nxt_st.ph = PH_IGN; // [R14]
            end
            if (fall) begin
                nxt_st.so = st_ff.tx[7]; // [R2] [R22]
                nxt_st.tx = {st_ff.tx[6:0], 1'b0};
            end
            if (rise) begin
                nxt_st.shr = b;
                nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                if (st_ff.bit_cnt == 3'h7) begin
                    case (st_ff.ph)
                        PH_OPC: begin
                            nxt_st.opc = b;
                            nxt_st.abytes = '0;
                            nxt_st.ph = PH_IGN;
                            case (b)
                                nvs_pkg::OP_READ, nvs_pkg::OP_FAST_READ, nvs_pkg::OP_WRITE: begin
                                    if (!busy) begin
                                        nxt_st.ph = PH_ADDR; // [R4] [R6] [R7] [R14]
                                    end
                                end
                                nvs_pkg::OP_WRITE_ENABLE: nxt_st.wel = 1'b1;
                                nvs_pkg::OP_WRITE_DISABLE: nxt_st.wel = 1'b0; // [R15]
                                nvs_pkg::OP_READ_STATUS: begin
                                    nxt_st.ph = PH_SRD;
                                    nxt_st.tx = stat; // [R14] [R20]
                                end
                                nvs_pkg::OP_WRITE_STATUS: nxt_st.ph = PH_WSR;
                                nvs_pkg::OP_STORE: go_store = 1'b1; // [R17]
                                nvs_pkg::OP_RECALL: go_recall = 1'b1; // [R17]
                                nvs_pkg::OP_POWER_LOSS_SAVE_OFF: nxt_st.save_en = 1'b0; // [R17]
                                nvs_pkg::OP_POWER_LOSS_SAVE_ON: nxt_st.save_en = 1'b1; // [R17]
                                default: nxt_st.ph = PH_IGN;
                            endcase
                        end
                        PH_ADDR: begin
                            // Upper address bits beyond the array fall away
                            nxt_st.addr = ADDR_W'({st_ff.addr, b}); // [R9] [R22]
                            nxt_st.abytes = st_ff.abytes + 2'h1;
                            if (st_ff.abytes == nvs_pkg::ADDR_BYTE_LAST) begin
                                if (st_ff.opc == nvs_pkg::OP_WRITE) begin
                                    nxt_st.ph = PH_WDATA; // [R4]
                                end else if (st_ff.opc == nvs_pkg::OP_FAST_READ) begin
                                    nxt_st.ph = PH_DUMMY; // [R7]
                                end else begin
                                    nxt_st.ph = PH_RDATA; // [R6]
                                    nxt_st.ld[0] = 1'b1;
                                end
                            end
                        end
                        PH_DUMMY: begin
                            nxt_st.ph = PH_RDATA; // [R7]
                            nxt_st.ld[0] = 1'b1;
                        end
                        PH_RDATA: begin
                            nxt_st.addr = st_ff.addr + 1'b1; // [R8]
                            nxt_st.ld[0] = 1'b1; // [R18]
                        end
                        PH_WDATA: begin
                            if (st_ff.wel && wp_n_s && !busy &&
                                !is_protected(st_ff.bp, st_ff.addr)) begin // [R15] [R16] [R14]
                                mem_we = 1'b1; // [R4] [R19]
                                mem_wd = b;
                                wrote = 1'b1;
                            end
                            nxt_st.addr = st_ff.addr + 1'b1; // [R5]
                        end
                        PH_SRD: nxt_st.tx = stat;
                        PH_WSR: begin
                            if (st_ff.wel && wp_n_s) begin
                                nxt_st.bp = b[nvs_pkg::ST_BLOCK_PROTECT_HI -: 2]; // [R15] [R16]
                            end
                            nxt_st.ph = PH_IGN;
                        end
                        default: nxt_st.ph = PH_IGN;
                    endcase
                end
            end
        end

        case (st_ff.nv)
            NV_IDLE: begin
                if (go_store || hw_req || save_req) begin
                    nxt_st.nv = NV_STORE; // [R17] [R21]
                    nxt_st.nv_ptr = '0;
                    nxt_st.dirty = 1'b0;
                end else if (go_recall) begin
                    nxt_st.nv = NV_RECALL; // [R17]
                    nxt_st.nv_ptr = '0;
                    nxt_st.dirty = 1'b0;
                end
            end
            NV_STORE: begin
                nv_we = 1'b1; // [R19]
                nxt_st.nv_ptr = st_ff.nv_ptr + 1'b1;
                if (&st_ff.nv_ptr) begin
                    nxt_st.nv = NV_DRIVE;
                    nxt_st.hi_cnt = '0;
                end
            end
            NV_RECALL: begin
                mem_we = 1'b1;
                mem_wa = st_ff.nv_ptr;
                mem_wd = nvm[st_ff.nv_ptr];
                nxt_st.nv_ptr = st_ff.nv_ptr + 1'b1;
                if (&st_ff.nv_ptr) begin
                    nxt_st.nv = NV_IDLE;
                end
            end
            NV_DRIVE: begin
                nxt_st.hi_cnt = st_ff.hi_cnt + 8'h1;
                if (st_ff.hi_cnt == HI_LAST) begin
                    nxt_st.nv = NV_IDLE; // [R11]
                end
            end
            default: nxt_st.nv = NV_IDLE;
        endcase
        // A write in the store's first cycle still marks the array
        if (wrote) begin
            nxt_st.dirty = 1'b1; // [R21]
        end
        nxt_st.busy_oe = (nxt_st.nv != NV_IDLE); // [R10] [R11]
        nxt_st.busy_o = (nxt_st.nv == NV_DRIVE); // [R11]
        nxt_st.nv_busy = (nxt_st.nv == NV_STORE) || (nxt_st.nv == NV_RECALL); // [R20]
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Arrays carry no reset; contents are undefined until written
    always_ff @(posedge MCLK) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        if (nv_we) begin
            nvm[st_ff.nv_ptr] <= mem[st_ff.nv_ptr];
        end
        rd_q <= mem[st_ff.addr];
    end

    assign LINK.so = st_ff.so;
    assign LINK.so_oe = st_ff.so_oe;
    assign LINK.store_busy_dev_o = st_ff.busy_o;
    assign LINK.store_busy_dev_oe = st_ff.busy_oe;
    assign NV_BUSY = st_ff.nv_busy;
    assign STANDBY = st_ff.standby;
    assign MEM_DIRTY = st_ff.dirty;
endmodule

// [verilog/nvs_host.sv]
// Controller end: byte-wise serial master behind a small register port
`timescale 1ns/1ps
module nvs_host #(
    parameter int HALF_CYC = nvs_pkg::HOST_HALF_DEF
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // Register port
    input wire logic [nvs_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [nvs_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [nvs_pkg::REG_DW-1:0] REG_RDATA,
    // Serial link
    nvs_link_if.host LINK
);
    // Below this the two-stage sampling on both ends misses bits
    if (HALF_CYC < nvs_pkg::HOST_HALF_MIN || HALF_CYC > 256) begin : g_bad_half
        $error("nvs_host: HALF_CYC out of range");
    end

    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);
    localparam logic [1:0] PIN_IDLE = 2'h2;

    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_SETUP = 6'h02,
        H_LOW = 6'h04,
        H_HIGH = 6'h08,
        H_END = 6'h10,
        H_GAP = 6'h20
    } nvs_hs_t;

    typedef struct packed {
        nvs_hs_t hs;
        logic [7:0] div;
        logic [2:0] bit_cnt;
        logic [7:0] txb;
        logic [7:0] rxb;
        logic keep;
        logic mode3;
        logic cs_n;
        logic sck;
        logic si;
        logic hold_n;
        logic wp_n;
        logic req_oe;
        logic [nvs_pkg::REG_DW-1:0] rdata;
    } nvs_host_st_t;

    localparam nvs_host_st_t ST_RST = '{hs: H_IDLE, cs_n: 1'b1, hold_n: 1'b1,
                                        wp_n: 1'b1, default: '0};

    nvs_host_st_t st_ff;
    nvs_host_st_t nxt_st;
    logic [1:0] pin_s;
    logic so_s;
    logic lvl_s;

    nvs_sync #(.W(2), .INIT(PIN_IDLE)) u_pin_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .d({LINK.store_busy_lvl, LINK.so}),
        .q(pin_s)
    );

    assign {lvl_s, so_s} = pin_s;

    always_comb begin
        logic tick, start, rel;
        nxt_st = st_ff;
        tick = (st_ff.div == HALF_LAST);
        nxt_st.div = tick ? '0 : st_ff.div + 8'h1;
        start = REG_WR && REG_ADDR == nvs_pkg::REG_CTRL && !REG_WDATA[nvs_pkg::CTRL_RELEASE];
        rel = REG_WR && REG_ADDR == nvs_pkg::REG_CTRL && REG_WDATA[nvs_pkg::CTRL_RELEASE];
        nxt_st.rdata = '0;
        if (REG_RD) begin
            case (REG_ADDR)
                nvs_pkg::REG_CFG: begin
                    nxt_st.rdata[nvs_pkg::CFG_MODE3] = st_ff.mode3; // [R3]
                    nxt_st.rdata[nvs_pkg::CFG_HOLD] = !st_ff.hold_n;
                    nxt_st.rdata[nvs_pkg::CFG_WP] = !st_ff.wp_n;
                    nxt_st.rdata[nvs_pkg::CFG_STORE_REQ] = st_ff.req_oe;
                end
                nvs_pkg::REG_STAT: begin
                    nxt_st.rdata[nvs_pkg::STAT_XFER] = !(st_ff.hs == H_IDLE || st_ff.hs == H_GAP);
                    nxt_st.rdata[nvs_pkg::STAT_NV_BUSY] = !lvl_s; // [R10]
                    nxt_st.rdata[nvs_pkg::STAT_FRAME] = !st_ff.cs_n;
                    nxt_st.rdata[nvs_pkg::STAT_RX +: 8] = st_ff.rxb;
                end
                default: nxt_st.rdata = '0;
            endcase
        end
        if (REG_WR && REG_ADDR == nvs_pkg::REG_CFG) begin
            nxt_st.mode3 = REG_WDATA[nvs_pkg::CFG_MODE3];
            nxt_st.hold_n = !REG_WDATA[nvs_pkg::CFG_HOLD]; // [R13]
            nxt_st.wp_n = !REG_WDATA[nvs_pkg::CFG_WP]; // [R15]
            nxt_st.req_oe = REG_WDATA[nvs_pkg::CFG_STORE_REQ]; // [R12]
        end
        case (st_ff.hs)
            H_IDLE: begin
                // Settle the clock before select falls, never with it
                nxt_st.sck = st_ff.mode3; // [R3]
                if (start) begin
                    nxt_st.txb = REG_WDATA[7:0];
                    nxt_st.keep = REG_WDATA[nvs_pkg::CTRL_KEEP];
                    nxt_st.cs_n = 1'b0; // [R1]
                    nxt_st.sck = st_ff.sck;
                    nxt_st.div = '0;
                    nxt_st.hs = H_SETUP;
                end
            end
            H_GAP: begin
                if (start) begin
                    nxt_st.txb = REG_WDATA[7:0];
                    nxt_st.keep = REG_WDATA[nvs_pkg::CTRL_KEEP];
                    nxt_st.si = REG_WDATA[7]; // [R22]
                    nxt_st.sck = 1'b0;
                    nxt_st.div = '0;
                    nxt_st.hs = H_LOW;
                end else if (rel) begin
                    nxt_st.div = '0;
                    nxt_st.hs = H_END;
                end
            end
            H_SETUP: begin
                if (tick) begin
                    nxt_st.sck = 1'b0;
                    nxt_st.si = st_ff.txb[7]; // [R22]
                    nxt_st.hs = H_LOW;
                end
            end
            H_LOW: begin
                if (tick) begin
                    nxt_st.sck = 1'b1;
                    nxt_st.rxb = {st_ff.rxb[6:0], so_s}; // [R2]
                    nxt_st.txb = {st_ff.txb[6:0], 1'b0};
                    nxt_st.hs = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tick) begin
                    nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
                    if (st_ff.bit_cnt == 3'h7) begin
                        nxt_st.sck = st_ff.mode3; // [R3]
                        nxt_st.hs = st_ff.keep ? H_GAP : H_END;
                    end else begin
                        nxt_st.sck = 1'b0; // [R2]
                        nxt_st.si = st_ff.txb[7];
                        nxt_st.hs = H_LOW;
                    end
                end
            end
            H_END: begin
                if (tick) begin
                    nxt_st.cs_n = 1'b1; // [R1] [R23]
                    nxt_st.hs = H_IDLE;
                end
            end
            default: nxt_st.hs = H_IDLE;
        endcase
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign REG_RDATA = st_ff.rdata;
    assign LINK.cs_n = st_ff.cs_n;
    assign LINK.sck = st_ff.sck;
    assign LINK.si = st_ff.si;
    assign LINK.hold_n = st_ff.hold_n;
    assign LINK.wp_n = st_ff.wp_n;
    assign LINK.store_busy_host_o = 1'b0;
    assign LINK.store_busy_host_oe = st_ff.req_oe;
endmodule

// [verilog/nvs_link_if.sv]
// Serial link between the memory end and the controller end
`timescale 1ns/1ps
interface nvs_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic hold_n;
    logic wp_n;
    logic store_busy_dev_o;
    logic store_busy_dev_oe;
    logic store_busy_host_o;
    logic store_busy_host_oe;
    logic store_busy_lvl;

    // Weak pull-up unless someone drives low
    assign store_busy_lvl = !((store_busy_dev_oe && !store_busy_dev_o) ||
                              (store_busy_host_oe && !store_busy_host_o));

    modport dev(
        input cs_n, sck, si, hold_n, wp_n, store_busy_lvl,
        output so, so_oe, store_busy_dev_o, store_busy_dev_oe
    );
    modport host(
        output cs_n, sck, si, hold_n, wp_n, store_busy_host_o, store_busy_host_oe,
        input so, so_oe, store_busy_lvl
    );
endinterface

// [verilog/nvs_pkg.sv]
// Shared constants of the nvSRAM serial access port, both ends
package nvs_pkg;
    localparam int CLK_NS = 4;
    localparam int MEM_ADDR_W = 17;
    localparam logic [1:0] ADDR_BYTE_LAST = 2'h2;

    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0b;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_STORE = 8'ha5;
    localparam logic [7:0] OP_RECALL = 8'h5a;
    localparam logic [7:0] OP_POWER_LOSS_SAVE_OFF = 8'h3d;
    localparam logic [7:0] OP_POWER_LOSS_SAVE_ON = 8'hd3;

    localparam int ST_READY = 0;
    localparam int ST_WRITE_EN = 1;
    localparam int ST_BLOCK_PROTECT_LO = 2;
    localparam int ST_BLOCK_PROTECT_HI = 3;
    localparam int ST_SAVE_EN = 6;

    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_ALL = 2'h3;

    localparam int DRIVE_HI_NS = 20;
    localparam int DRIVE_HI_CYC = (DRIVE_HI_NS + CLK_NS - 1) / CLK_NS;

    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam int CTRL_KEEP = 8;
    localparam int CTRL_RELEASE = 9;
    localparam int CFG_MODE3 = 0;
    localparam int CFG_HOLD = 1;
    localparam int CFG_WP = 2;
    localparam int CFG_STORE_REQ = 3;
    localparam int STAT_XFER = 0;
    localparam int STAT_NV_BUSY = 1;
    localparam int STAT_FRAME = 2;
    localparam int STAT_RX = 8;
    localparam int HOST_HALF_DEF = 8;
    localparam int HOST_HALF_MIN = 8;
endpackage

// [verilog/nvs_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module nvs_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= INIT;
            q <= INIT;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule
